// File: sitp_params.svh
`ifndef SITP_PARAMS_SVH
`define SITP_PARAMS_SVH
`define SITP_TARGET_ADDR 7'h57
`define SITP_RW_WRITE 1'b0
`define SITP_RW_READ 1'b1
`define SITP_BYTE_BITS 4'h8
`define SITP_ADDR_BITS 4'h7
`define SITP_REG_AW 8
`define SITP_PTR_RESET 8'h00
`define SITP_FIFO_DATA_REG 8'h07
`define SITP_INT_STATUS_REG 8'h00
`define SITP_MAX_SCL_HZ 400000
`define SITP_CLK_HZ 25000000
`define SITP_MIN_CLKS_PER_SCL_HALF ((`SITP_CLK_HZ / `SITP_MAX_SCL_HZ) / 2)
`endif

// File: sitp_pkg.sv
package sitp_pkg;
  typedef enum logic [2:0] {
    SITP_IDLE = 3'b000,
    SITP_ADDR = 3'b001,
    SITP_ADDR_ACK = 3'b010,
    SITP_WR_BYTE = 3'b011,
    SITP_WR_ACK = 3'b100,
    SITP_RD_BYTE = 3'b101,
    SITP_RD_ACK = 3'b110,
    SITP_IGNORE = 3'b111
  } sitp_state_t;
endpackage

// File: sitp_sync.sv
`timescale 1ns/10ps
module sitp_sync (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Asynchronous input and synchronised output
  input wire logic d_i,
  output logic q_o
);
  logic meta;
  logic next_meta;
  logic next_q;

  always_comb begin
    next_meta = d_i;
    next_q = meta;
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta <= 1'b1;
      q_o <= 1'b1;
    end else begin
      meta <= next_meta;
      q_o <= next_q;
    end
  end
endmodule // sitp_sync

// File: sitp_ready_flag.sv
`timescale 1ns/10ps
module sitp_ready_flag (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Clear on read of the status register
  input wire logic clear_i,
  // Ready flag
  output logic ready_o
);
  logic next_ready;

  always_comb begin
    next_ready = ready_o;
    if (clear_i) begin
      next_ready = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ready_o <= 1'b1;
    end else begin
      ready_o <= next_ready;
    end
  end

  a_ready_clears: assert property (@(posedge clk_i) disable iff (!nrst_i)
    clear_i |=> !ready_o) else $error("ready flag not cleared by status read");
  a_ready_stays: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !ready_o |=> !ready_o) else $error("ready flag came back");
endmodule // sitp_ready_flag

// File: sitp_target.sv
`timescale 1ns/10ps
`include "sitp_params.svh"
// Functional notes
// - After power-up the ready interrupt asserts; reading interrupt status clears it.
// - Port works with bus clocks up to 400 kHz; the bench master runs its clock above that, at 3.125 MHz.
// - Each byte is eight bits plus a ninth acknowledge clock.
// - One bit per clock; data changes while clock high are conditions.
// - Data falling with clock high is START; rising is STOP.
// - Both lines rest high when idle; nobody holds them low.
// - Repeated START keeps the bus and begins a new addressed transfer.
// - STOP honoured anywhere, except in the same clock-high pulse as START.
// - Address compared bit by bit; first mismatch ignores bus until START.
// - Target address is 1010111, sent most significant bit first.
// - Last address bit: 0 means write, 1 means read.
// - On address match, hold data low for the acknowledge clock.
// - In write, hold data low for whole ninth pulse per received byte.
// - In read, shift data out open-drain in step with master clock.
// - Write is address, register address, data; pointer advances per data byte except at the FIFO data register.
// - Read pointer advances per byte except at the FIFO data register.
module sitp_target (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Serial bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  // Register file side
  output logic [`SITP_REG_AW-1:0] reg_addr_o,
  output logic [7:0] wr_data_o,
  output logic wr_stb_o,
  output logic rd_stb_o,
  input wire logic [7:0] rd_data_i,
  // Ready interrupt, open-drain, active low
  output logic int_n_o,
  output logic int_n_oe_n_o
);
  logic scl_s;
  logic sda_s;
  logic scl_d;
  logic sda_d;
  logic ready;
  logic rd_clear;

  sitp_sync u_sync_scl (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .d_i(scl_i),
    .q_o(scl_s)
  );

  sitp_sync u_sync_sda (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .d_i(sda_i),
    .q_o(sda_s)
  );

  sitp_ready_flag u_ready (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .clear_i(rd_clear),
    .ready_o(ready)
  );

  // Bus state
  sitp_pkg::sitp_state_t state;
  sitp_pkg::sitp_state_t next_state;
  logic [3:0] bit_cnt;
  logic [3:0] next_bit_cnt;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic rw;
  logic next_rw;
  logic have_ptr;
  logic next_have_ptr;
  logic start_pulse;
  logic next_start_pulse;
  logic master_ack;
  logic next_master_ack;
  logic next_sda_oe_n;
  logic [`SITP_REG_AW-1:0] next_reg_addr;
  logic [7:0] next_wr_data;
  logic next_wr_stb;
  logic next_rd_stb;
  logic next_rd_clear;
  logic next_int_n_oe_n;

  // Fixed target address, compared one bit per bus clock, MSB first
  localparam logic [6:0] TARGET_ADDR = `SITP_TARGET_ADDR;

  if (`SITP_MIN_CLKS_PER_SCL_HALF < 4) begin : g_clk_check
    $error("system clock too slow for the fastest bus clock");
  end

  wire scl_rise = scl_s && !scl_d;
  wire scl_fall = !scl_s && scl_d;
  wire start_cond = scl_s && scl_d && sda_d && !sda_s;
  wire stop_cond = scl_s && scl_d && !sda_d && sda_s;

  function automatic logic [`SITP_REG_AW-1:0] ptr_step(input logic [`SITP_REG_AW-1:0] p);
    if (p == `SITP_FIFO_DATA_REG) begin
      ptr_step = p;
    end else begin
      ptr_step = p + 8'h01;
    end
  endfunction

  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_shreg = shreg;
    next_rw = rw;
    next_have_ptr = have_ptr;
    next_master_ack = master_ack;
    next_sda_oe_n = sda_oe_n_o;
    next_reg_addr = reg_addr_o;
    next_wr_data = wr_data_o;
    next_wr_stb = 1'b0;
    next_rd_stb = 1'b0;
    next_rd_clear = 1'b0;
    next_start_pulse = start_pulse;
    next_int_n_oe_n = !ready;
    if (!scl_s) begin
      next_start_pulse = 1'b0;
    end
    if (start_cond) begin
      // Repeated START restarts addressing without giving up the bus
      next_state = sitp_pkg::SITP_ADDR;
      next_bit_cnt = 4'h0;
      next_sda_oe_n = 1'b1;
      next_start_pulse = 1'b1;
    end else if (stop_cond && !start_pulse) begin
      next_state = sitp_pkg::SITP_IDLE;
      next_sda_oe_n = 1'b1;
    end else if (scl_rise) begin
      // Data sampled on clock rise, so it is stable while high
      unique case (state)
        sitp_pkg::SITP_ADDR: begin
          next_shreg = {shreg[6:0], sda_s};
          next_bit_cnt = bit_cnt + 4'h1;
          if (bit_cnt < `SITP_ADDR_BITS && sda_s != TARGET_ADDR[3'(4'h6 - bit_cnt)]) begin
            next_state = sitp_pkg::SITP_IGNORE;
          end
          if (bit_cnt == `SITP_ADDR_BITS) begin
            next_rw = sda_s;
          end
        end
        sitp_pkg::SITP_WR_BYTE: begin
          next_shreg = {shreg[6:0], sda_s};
          next_bit_cnt = bit_cnt + 4'h1;
        end
        sitp_pkg::SITP_RD_ACK: begin
          next_master_ack = !sda_s;
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      unique case (state)
        sitp_pkg::SITP_ADDR: begin
          if (bit_cnt == `SITP_BYTE_BITS) begin
            next_state = sitp_pkg::SITP_ADDR_ACK;
            next_sda_oe_n = 1'b0;
            next_have_ptr = 1'b0;
          end
        end
        sitp_pkg::SITP_ADDR_ACK: begin
          next_bit_cnt = 4'h0;
          if (rw == `SITP_RW_READ) begin
            next_state = sitp_pkg::SITP_RD_BYTE;
            next_shreg = {rd_data_i[6:0], 1'b0};
            next_sda_oe_n = rd_data_i[7];
            next_rd_stb = 1'b1;
            next_rd_clear = (reg_addr_o == `SITP_INT_STATUS_REG);
          end else begin
            next_state = sitp_pkg::SITP_WR_BYTE;
            next_sda_oe_n = 1'b1;
          end
        end
        sitp_pkg::SITP_WR_BYTE: begin
          if (bit_cnt == `SITP_BYTE_BITS) begin
            next_state = sitp_pkg::SITP_WR_ACK;
            next_sda_oe_n = 1'b0;
            if (!have_ptr) begin
              next_reg_addr = shreg;
              next_have_ptr = 1'b1;
            end else begin
              next_wr_data = shreg;
              next_wr_stb = 1'b1;
            end
          end
        end
        sitp_pkg::SITP_WR_ACK: begin
          next_state = sitp_pkg::SITP_WR_BYTE;
          next_sda_oe_n = 1'b1;
          next_bit_cnt = 4'h0;
          if (wr_stb_o || have_ptr && bit_cnt == `SITP_BYTE_BITS && shreg != reg_addr_o) begin
            next_reg_addr = reg_addr_o;
          end
        end
        sitp_pkg::SITP_RD_BYTE: begin
          next_bit_cnt = bit_cnt + 4'h1;
          if (bit_cnt == 4'h7) begin
            next_state = sitp_pkg::SITP_RD_ACK;
            next_sda_oe_n = 1'b1;
            next_reg_addr = ptr_step(reg_addr_o);
          end else begin
            next_sda_oe_n = shreg[7];
            next_shreg = {shreg[6:0], 1'b0};
          end
        end
        sitp_pkg::SITP_RD_ACK: begin
          next_bit_cnt = 4'h0;
          if (master_ack) begin
            next_state = sitp_pkg::SITP_RD_BYTE;
            next_shreg = {rd_data_i[6:0], 1'b0};
            next_sda_oe_n = rd_data_i[7];
            next_rd_stb = 1'b1;
            next_rd_clear = (reg_addr_o == `SITP_INT_STATUS_REG);
          end else begin
            next_state = sitp_pkg::SITP_IGNORE;
          end
        end
        default: begin
        end
      endcase
    end
    if (wr_stb_o) begin
      next_reg_addr = ptr_step(reg_addr_o);
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      state <= sitp_pkg::SITP_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      rw <= 1'b0;
      have_ptr <= 1'b0;
      start_pulse <= 1'b0;
      master_ack <= 1'b0;
      sda_oe_n_o <= 1'b1;
      reg_addr_o <= `SITP_PTR_RESET;
      wr_data_o <= 8'h00;
      wr_stb_o <= 1'b0;
      rd_stb_o <= 1'b0;
      rd_clear <= 1'b0;
      int_n_oe_n_o <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      shreg <= next_shreg;
      rw <= next_rw;
      have_ptr <= next_have_ptr;
      start_pulse <= next_start_pulse;
      master_ack <= next_master_ack;
      sda_oe_n_o <= next_sda_oe_n;
      reg_addr_o <= next_reg_addr;
      wr_data_o <= next_wr_data;
      wr_stb_o <= next_wr_stb;
      rd_stb_o <= next_rd_stb;
      rd_clear <= next_rd_clear;
      int_n_oe_n_o <= next_int_n_oe_n;
    end
  end

  // Open-drain pins only ever pull low; clock is never driven
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sda_o <= 1'b0;
      int_n_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
      int_n_o <= 1'b0;
    end
  end

  a_ignore_holds: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (state == sitp_pkg::SITP_IGNORE && !start_cond && !stop_cond)
    |=> (state == sitp_pkg::SITP_IGNORE && sda_oe_n_o)) else $error("target answered after mismatch");
  a_addr_ack_low: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (state == sitp_pkg::SITP_ADDR_ACK) |-> !sda_oe_n_o) else $error("address ack not driven");
  a_wr_ack_low: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (state == sitp_pkg::SITP_WR_ACK) |-> !sda_oe_n_o) else $error("write ack not driven");
  a_idle_released: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (state == sitp_pkg::SITP_IDLE) |-> sda_oe_n_o) else $error("data held low while idle");
  a_start_to_addr: assert property (@(posedge clk_i) disable iff (!nrst_i)
    start_cond |=> state == sitp_pkg::SITP_ADDR && bit_cnt == 4'h0) else $error("START not decoded");
  a_stop_to_idle: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (stop_cond && !start_pulse) |=> state == sitp_pkg::SITP_IDLE) else $error("STOP not honoured");
  a_fifo_ptr_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (state == sitp_pkg::SITP_RD_BYTE && scl_fall && bit_cnt == 4'h7 && reg_addr_o == `SITP_FIFO_DATA_REG
     && !start_cond && !stop_cond) |=> $stable(reg_addr_o)) else $error("pointer moved at FIFO data");
  a_wr_ptr_step: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (wr_stb_o && reg_addr_o != `SITP_FIFO_DATA_REG) |=> reg_addr_o == $past(reg_addr_o) + 8'h01)
    else $error("pointer not advanced after write");
  a_rd_release_ack: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (state == sitp_pkg::SITP_RD_ACK) |-> sda_oe_n_o) else $error("data driven in master ack slot");
endmodule // sitp_target

// File: sitp_bus_master.sv
`timescale 1ns/10ps
module sitp_bus_master #(
  parameter int QTR_CLKS = 2
) (
  // Bench clock, bus lines change just after its rising edge
  input wire logic clk_i,
  // Bus lines, open drain, released high
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // One quarter of a bus clock period
  task automatic qtr();
    repeat (QTR_CLKS) @(posedge clk_i);
  endtask
  // Start or repeated start, bus stays claimed
  task automatic start();
    qtr();
    sda_o <= 1'b1;
    qtr();
    scl_o <= 1'b1;
    qtr();
    sda_o <= 1'b0;
    qtr();
    scl_o <= 1'b0;
  endtask
  // Start followed by a stop inside the same clock-high pulse
  task automatic start_stop();
    qtr();
    sda_o <= 1'b1;
    qtr();
    scl_o <= 1'b1;
    qtr();
    sda_o <= 1'b0;
    qtr();
    sda_o <= 1'b1;
    qtr();
    scl_o <= 1'b0;
  endtask
  task automatic stop();
    qtr();
    sda_o <= 1'b0;
    qtr();
    scl_o <= 1'b1;
    qtr();
    sda_o <= 1'b1;
    qtr();
  endtask
  // Shift n bits MSB first; data moves only while the clock is low
  task automatic xfer(input logic [8:0] v, input int n, output logic [8:0] got);
    got = 9'h000;
    for (int i = 8; i > 8 - n; i--) begin
      qtr();
      sda_o <= v[i];
      qtr();
      scl_o <= 1'b1;
      qtr();
      got = {got[7:0], sda_i};
      qtr();
      scl_o <= 1'b0;
    end
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack_n);
    logic [8:0] g;
    xfer({b, 1'b1}, 9, g);
    ack_n = g[0];
  endtask
  task automatic rbyte(input logic nack, output logic [7:0] b);
    logic [8:0] g;
    xfer({8'hFF, nack}, 9, g);
    b = g[8:1];
  endtask
endmodule // sitp_bus_master

// File: sitp_target_tb.sv
`timescale 1ns/10ps
`include "sitp_params.svh"
module sitp_target_tb;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic scl, m_sda, sda_w, sda_o, sda_oe_n, wr_stb, int_oe_n;
  logic rd_stb, int_drv, int_pin;
  int n_rd = 0;
  logic [7:0] reg_addr, wr_data, rd_data;
  logic [7:0] mem [0:255];
  int n_fail = 0;
  int comparisons = 0;
  always #20 clk_i = ~clk_i;
  // Wired-and of the pull-up, the master and the target
  assign sda_w = m_sda & (sda_oe_n | sda_o);
  assign rd_data = mem[reg_addr];
  // Interrupt pin with its pull-up
  assign int_pin = int_oe_n | int_drv;
  always @(posedge clk_i) begin
    if (wr_stb) mem[reg_addr] <= wr_data;
    if (rd_stb) n_rd++;
  end
  sitp_bus_master host (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl), .sda_o(m_sda));
  sitp_target dut (.clk_i(clk_i), .nrst_i(nrst_i), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n), .reg_addr_o(reg_addr), .wr_data_o(wr_data), .wr_stb_o(wr_stb),
    .rd_stb_o(rd_stb), .rd_data_i(rd_data), .int_n_o(int_drv), .int_n_oe_n_o(int_oe_n));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d, n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Address phase and register pointer byte
  task automatic set_ptr(input logic [7:0] ra);
    logic a;
    host.start();
    host.wbyte({`SITP_TARGET_ADDR, `SITP_RW_WRITE}, a);
    check({7'h00, a}, 8'h00);
    host.wbyte(ra, a);
    check({7'h00, a}, 8'h00);
  endtask
  task automatic t_write();
    logic a;
    set_ptr(8'h10);
    host.wbyte(8'hA5, a);
    check({7'h00, a}, 8'h00);
    host.wbyte(8'h3C, a);
    check({7'h00, a}, 8'h00);
    host.stop();
    check(mem[8'h10], 8'hA5);
    check(mem[8'h11], 8'h3C);
  endtask
  task automatic t_read(input logic [7:0] ra, input logic [7:0] e0, input logic [7:0] e1);
    logic a;
    logic [7:0] d;
    set_ptr(ra);
    host.start();
    host.wbyte({`SITP_TARGET_ADDR, `SITP_RW_READ}, a);
    check({7'h00, a}, 8'h00);
    host.rbyte(1'b0, d);
    check(d, e0);
    host.rbyte(1'b1, d);
    check(d, e1);
    host.stop();
  endtask
  task automatic t_wrong_addr(input logic [6:0] flip);
    logic a;
    host.start();
    host.wbyte({`SITP_TARGET_ADDR ^ flip, `SITP_RW_WRITE}, a);
    check({7'h00, a}, 8'h01);
    host.wbyte({`SITP_TARGET_ADDR, `SITP_RW_WRITE}, a);
    check({7'h00, a}, 8'h01);
    host.stop();
    set_ptr(8'h30);
    host.stop();
  endtask
  task automatic t_early_stop();
    logic [8:0] g;
    logic a;
    set_ptr(8'h20);
    host.xfer(9'h1F0, 4, g);
    host.stop();
    check(mem[8'h20], 8'h00);
    host.wbyte(8'hAE, a);
    check({7'h00, a}, 8'h01);
    host.stop();
  endtask
  task automatic t_stop_in_start();
    logic a;
    host.start_stop();
    host.wbyte({`SITP_TARGET_ADDR, `SITP_RW_WRITE}, a);
    check({7'h00, a}, 8'h00);
    host.wbyte(8'h40, a);
    check({7'h00, a}, 8'h00);
    host.wbyte(8'h77, a);
    check({7'h00, a}, 8'h00);
    host.stop();
    check(mem[8'h40], 8'h77);
  endtask
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'h00;
    mem[8'h00] = 8'h80;
    mem[8'h07] = 8'h5A;
    mem[8'h08] = 8'h99;
    repeat (16) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    check({7'h00, int_oe_n}, 8'h00);
    check({7'h00, sda_oe_n}, 8'h01);
    check({7'h00, int_pin}, 8'h00);
    t_write();
    t_read(8'h10, 8'hA5, 8'h3C);
    t_read(8'h07, 8'h5A, 8'h5A);
    check({7'h00, int_oe_n}, 8'h00);
    t_wrong_addr(7'h40);
    t_wrong_addr(7'h01);
    t_early_stop();
    t_stop_in_start();
    t_read(8'h00, 8'h80, 8'h00);
    repeat (4) @(posedge clk_i);
    check({7'h00, int_oe_n}, 8'h01);
    check({7'h00, int_pin}, 8'h01);
    check(n_rd[7:0], 8'h06);
    test_done();
  end
  // Watchdog against a hung bus
  initial begin
    #3000000;
    n_fail++;
    test_done();
  end
endmodule // sitp_target_tb
